/* hdl/adg_core.sv */
// address generator core: instruction execution, address/data ports, avalon registers
// assumes instruction pins synchronous to sys_clk; data port resolved outside from oe
`timescale 1ns/100ps
`default_nettype none
module adg_core
    import adg_pkg::*;
#(
    parameter int ADDR_W = ADG_ADDR_W,
    parameter int NUM_R  = ADG_NUM_R
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // instruction port from the sequencer
    input  wire adg_ins_t    ins_in,
    // shared data bus
    input  wire logic [15:0] d_in,
    output logic      [15:0] d_out,
    output logic             d_oe,
    // address port and compare flag
    output logic      [15:0] y_out,
    output logic             y_oe,
    output logic             compare_zero_flag_pin,
    output logic             flag_oe,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);

    // -------------------------------------------------------------------
    // elaboration check
    // -------------------------------------------------------------------
    // the reversing network and the register index are wired for sixteen;
    // a narrower reversal must be done in software with a pre-reversed start
    if (ADDR_W != 16 || NUM_R != 16) begin : g_bad_param
        $error("adg_core serves only a 16-bit address and sixteen registers");
    end

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    // register files are flip-flops indexed by field, so any entry reads at once
    logic [15:0]  r_q [16];
    logic [15:0]  r_d [16];
    logic [15:0]  b_q [8];
    logic [15:0]  b_d [8];
    logic [15:0]  c_q [4];
    logic [15:0]  c_d [4];
    logic [15:0]  i_q [4];
    logic [15:0]  i_d [4];
    logic [10:0]  cr_q;
    logic [10:0]  cr_d;
    logic [9:0]   air_q;
    logic [9:0]   air_d;
    // toggle stands in for the two-phase clock
    logic         phase_q;
    logic         phase_d;
    adg_ins_t     ins_q;
    adg_ins_t     ins_d;
    logic [15:0]  din_q;
    logic [15:0]  din_d;
    logic         alt_q;
    logic         alt_d;
    logic         flag_q;
    logic         flag_d;
    logic [15:0]  y_q;
    logic [15:0]  y_d;
    logic         yoe_q;
    logic         yoe_d;
    logic         flagoe_q;
    logic         flagoe_d;
    logic [15:0]  dout_q;
    logic [15:0]  dout_d;
    logic         doe_q;
    logic         doe_d;
    logic         wait_q;
    logic         wait_d;
    logic [31:0]  rdata_q;
    logic [31:0]  rdata_d;
    // write strobe qualified by the accepting edge
    logic         bus_wr;

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    // mirror across all sixteen bits; no narrower width is offered
    function automatic logic [15:0] bit_rev(input logic [15:0] v);
        logic [15:0] o;
        o = 16'h0000;
        for (int k = 0; k < 16; k++) begin
            o[k] = v[15 - k];
        end
        return o;
    endfunction

    // offset operand: data port stands in for the offset register when selected
    function automatic logic [15:0] offset_of(input adg_code_t c, input logic ds, input logic [15:0] dv);
        logic [2:0] bi;
        bi = {cr_q[ADG_CR_BBANK], c.psel};
        return ds ? dv : b_q[bi];
    endfunction

    // value placed on the address port for a given instruction
    function automatic logic [15:0] addr_of(input adg_code_t c, input logic ds, input logic [15:0] dv);
        logic [15:0] rv;
        logic [15:0] sum;
        rv  = r_q[c.rsel];
        sum = 16'h0000;
        if (c.op == OP_ADD) begin
            sum = rv + offset_of(c, ds, dv);
        end else if (c.op == OP_SUB) begin
            sum = rv - offset_of(c, ds, dv);
        end
        case (c.op)
            OP_PASS:        return dv;
            OP_BITREV:      return bit_rev(rv);
            OP_ADD, OP_SUB: return cr_q[ADG_CR_POST] ? sum : rv;
            default:        return rv;
        endcase
    endfunction

    // only output-type ops drive the address port; the rest leave it released
    function automatic logic drives_addr(input adg_op_t op);
        return op == OP_PASS || op == OP_BITREV || op == OP_ADD || op == OP_SUB;
    endfunction

    // -------------------------------------------------------------------
    // avalon slave: one wait cycle, then the answer at the accepting edge
    // -------------------------------------------------------------------
    // a write lands only at the edge where the master sees waitrequest low,
    // so a request that is dropped early never half-updates a register
    assign bus_wr = avs_write && !wait_q;

    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        if ((avs_read || avs_write) && wait_q) begin
            wait_d = 1'b0;
            if (avs_read) begin
                case (avs_address)
                    ADG_OFS_CTRL:   rdata_d = {21'h000000, cr_q};
                    ADG_OFS_ALT:    rdata_d = {22'h000000, air_q};
                    ADG_OFS_STATUS: rdata_d = {27'h0000000, doe_q, yoe_q, phase_q, alt_q, flag_q};
                    ADG_OFS_YOUT:   rdata_d = {16'h0000, y_q};
                    default:        rdata_d = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // -------------------------------------------------------------------
    // instruction capture and execution
    // -------------------------------------------------------------------
    // phase_q low: phase two, inputs sampled at its closing edge.
    // phase_q high: phase one, inputs held, the latched word executes.
    always_comb begin
        adg_code_t  cur;
        logic [15:0] rv;
        logic [15:0] sum;
        logic [15:0] cmp_v;
        logic        cmp;
        cur     = ins_q.code;
        rv      = 16'h0000;
        sum     = 16'h0000;
        cmp_v   = 16'h0000;
        cmp     = 1'b0;
        r_d     = r_q;
        b_d     = b_q;
        c_d     = c_q;
        i_d     = i_q;
        cr_d    = cr_q;
        air_d   = air_q;
        ins_d   = ins_q;
        din_d   = din_q;
        alt_d   = alt_q;
        flag_d  = flag_q;
        y_d     = y_q;
        yoe_d   = yoe_q;
        flagoe_d = flagoe_q;
        dout_d  = dout_q;
        doe_d   = 1'b0;
        phase_d = ~phase_q;

        if (!phase_q) begin
            // start of phase one: latch inputs, ignore them until the next phase two
            ins_d = ins_in;
            din_d = d_in;
            // drivers fall after one cycle so an outside driver may take the bus
            // in phase two without contention
            if (ins_in.code.op == OP_RTD) begin
                dout_d = r_q[ins_in.code.rsel];
                doe_d  = 1'b1;
            end
            // limitation: the flow-through path is one registered stage here,
            // traded for outputs that all come from flip-flops
            if (cr_q[ADG_CR_TRANSP] && !ins_in.alternate_exec_enable_pin && !alt_q) begin
                // transparent: address follows the new word at once
                y_d   = addr_of(ins_in.code, ins_in.data_select_pin, d_in);
                yoe_d = drives_addr(ins_in.code.op);
                flagoe_d = ins_in.code.op != OP_IDLE;
            end
        end else begin
            // reset instruction wins over any pending alternate word
            if ((alt_q || ins_q.alternate_exec_enable_pin) && ins_q.code.op != OP_RST) begin
                cur = adg_code_t'(air_q);
            end
            // an alternate word runs once; a fresh match arms it again
            alt_d = 1'b0;
            rv    = r_q[cur.rsel];
            if (!cr_q[ADG_CR_TRANSP] || alt_q || ins_q.alternate_exec_enable_pin) begin
                y_d   = addr_of(cur, ins_q.data_select_pin, din_q);
                yoe_d = drives_addr(cur.op);
                flagoe_d = cur.op != OP_IDLE;
            end
            case (cur.op)
                OP_IDLE: begin
                    // nothing stored; every pin released
                    yoe_d    = 1'b0;
                    flagoe_d = 1'b0;
                end
                OP_PASS: begin
                end
                // stored sum uses the unreversed value, so a pre-reversed start steps right
                OP_BITREV: begin
                    r_d[cur.rsel] = rv + offset_of(cur, ins_q.data_select_pin, din_q);
                end
                OP_ADD, OP_SUB: begin
                    if (cur.op == OP_ADD) begin
                        sum = rv + offset_of(cur, ins_q.data_select_pin, din_q);
                    end else begin
                        sum = rv - offset_of(cur, ins_q.data_select_pin, din_q);
                    end
                    r_d[cur.rsel] = sum;
                    cmp_v  = cr_q[ADG_CR_POST] ? sum : rv;
                    // unsigned compare: an address that wraps past zero reads true
                    cmp    = cmp_v >= c_q[cur.psel];
                    flag_d = cmp;
                    if (cmp) begin
                        if (cr_q[ADG_CR_ALTX]) begin
                            alt_d = 1'b1;
                        end else if (cr_q[cur.psel]) begin
                            r_d[cur.rsel] = i_q[cur.psel];
                        end
                    end
                end
                OP_SETY: cr_d[ADG_CR_TRANSP] = cur.psel[0];
                OP_SETU: cr_d[ADG_CR_POST]   = cur.psel[0];
                OP_SETA: cr_d[ADG_CR_ALTX]   = cur.psel[0];
                OP_SELB: cr_d[ADG_CR_BBANK]  = cur.psel[0];
                OP_DTR:  r_d[cur.rsel] = din_q;
                OP_DTB:  b_d[cur.rsel[2:0]] = din_q;
                OP_DTC:  c_d[cur.psel] = din_q;
                OP_DTI:  i_d[cur.psel] = din_q;
                OP_WRA:  air_d = din_q[9:0];
                OP_RST:  cr_d = ADG_CR_RESET;
                OP_RTD: begin
                end
                default: begin
                end
            endcase
        end

        // software access overrides the same-cycle instruction update
        // software changing mode bits mid-program should do so between loops
        if (bus_wr && avs_address == ADG_OFS_CTRL) begin
            cr_d = avs_writedata[10:0];
        end
        if (bus_wr && avs_address == ADG_OFS_ALT) begin
            air_d = avs_writedata[9:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            // the whole register file clears in one edge
            for (int k = 0; k < 16; k++) begin
                r_q[k] <= 16'h0000;
            end
            for (int k = 0; k < 8; k++) begin
                b_q[k] <= 16'h0000;
            end
            for (int k = 0; k < 4; k++) begin
                c_q[k] <= 16'h0000;
                i_q[k] <= 16'h0000;
            end
            cr_q     <= ADG_CR_RESET;
            air_q    <= 10'h000;
            phase_q  <= 1'b0;
            ins_q    <= '0;
            din_q    <= 16'h0000;
            alt_q    <= 1'b0;
            flag_q   <= 1'b0;
            y_q      <= 16'h0000;
            yoe_q    <= 1'b0;
            flagoe_q <= 1'b0;
            dout_q   <= 16'h0000;
            doe_q    <= 1'b0;
        end else begin
            r_q      <= r_d;
            b_q      <= b_d;
            c_q      <= c_d;
            i_q      <= i_d;
            cr_q     <= cr_d;
            air_q    <= air_d;
            phase_q  <= phase_d;
            ins_q    <= ins_d;
            din_q    <= din_d;
            alt_q    <= alt_d;
            flag_q   <= flag_d;
            y_q      <= y_d;
            yoe_q    <= yoe_d;
            flagoe_q <= flagoe_d;
            dout_q   <= dout_d;
            doe_q    <= doe_d;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    // every pin and enable comes straight from a flip-flop
    assign y_out                 = y_q;
    assign y_oe                  = yoe_q;
    assign compare_zero_flag_pin = flag_q;
    assign flag_oe               = flagoe_q;
    assign d_out                 = dout_q;
    assign d_oe                  = doe_q;
    assign avs_readdata          = rdata_q;
    assign avs_waitrequest       = wait_q;

endmodule
`default_nettype wire

/* hdl/adg_pkg.sv */
// package of constants and types for the address generator core
// assumes one 200 MHz clock and a synchronous, active-high reset
// Function
// - pass-through op drives data port value onto address port, registers untouched
// - bit-reversed op outputs selected address register with bit order mirrored
// - bit-reversed op adds selected offset to unreversed register and stores sum back
// - bit-reversed op performs no compare, so no reload and no alternate execution
// - reversal touches only the output value, never the stored register value
// - idle instruction changes no register, flag or mode state
// - idle instruction releases every output pin to high impedance
// - reversal spans exactly the full 16-bit address width
// - data port may replace offset operand, result kept in any of sixteen registers
// - transparent, post-update and data select together give a flow-through adder
// - control bit 10 enables conditional alternate-instruction execution from looping ops
// - looping compare true in that mode runs the alternate instruction next cycle
// - comparator is true when address register is at least the compare register
// - pre-update outputs before adding; post-update adds first, then outputs
// - two-phase cycle, phase one high and phase two low, one instruction each
// - controller sets instruction, data select, alternate enable early; device latches them in phase one
// - data drivers enabled only in phase one for data output ops
// - transparent mode with data select opens data port to address port path
// - instruction and data select changes during phase one are ignored
// - transparent mode address follows the instruction without waiting for execution
// - control bit 6 high selects transparent, low selects latched address output
// - control bit 9 set selects post-update mode
// - alternate-instruction mode suppresses compare-driven reload from initial registers
package adg_pkg;

    // -------------------------------------------------------------------
    // widths and counts
    // -------------------------------------------------------------------
    localparam int ADG_ADDR_W   = 16;
    localparam int ADG_NUM_R    = 16;
    localparam int ADG_NUM_B    = 8;
    localparam int ADG_NUM_C    = 4;
    localparam int ADG_INS_W    = 10;
    localparam int ADG_CR_W     = 11;

    // -------------------------------------------------------------------
    // control register fields and reset value
    // -------------------------------------------------------------------
    localparam int ADG_CR_TRANSP   = 6;
    localparam int ADG_CR_BBANK    = 8;
    localparam int ADG_CR_POST     = 9;
    localparam int ADG_CR_ALTX     = 10;
    localparam logic [10:0] ADG_CR_RESET = 11'h000;

    // -------------------------------------------------------------------
    // avalon register byte offsets
    // -------------------------------------------------------------------
    localparam logic [3:0] ADG_OFS_CTRL   = 4'h0;
    localparam logic [3:0] ADG_OFS_ALT    = 4'h4;
    localparam logic [3:0] ADG_OFS_STATUS = 4'h8;
    localparam logic [3:0] ADG_OFS_YOUT   = 4'hc;

    // -------------------------------------------------------------------
    // instruction opcodes, held in bits 9:6
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_IDLE   = 4'h0,
        OP_PASS   = 4'h1,
        OP_BITREV = 4'h2,
        OP_ADD    = 4'h3,
        OP_SUB    = 4'h4,
        OP_SETY   = 4'h5,
        OP_SETU   = 4'h6,
        OP_SETA   = 4'h7,
        OP_DTR    = 4'h8,
        OP_DTB    = 4'h9,
        OP_DTC    = 4'ha,
        OP_DTI    = 4'hb,
        OP_RTD    = 4'hc,
        OP_WRA    = 4'hd,
        OP_RST    = 4'he,
        OP_SELB   = 4'hf
    } adg_op_t;

    // instruction word: opcode, address register index, pair index
    typedef struct packed {
        adg_op_t    op;
        logic [3:0] rsel;
        logic [1:0] psel;
    } adg_code_t;

    // inputs latched together in phase one
    typedef struct packed {
        adg_code_t code;
        logic      data_select_pin;
        logic      alternate_exec_enable_pin;
    } adg_ins_t;

endpackage

/* verif/adg_core_props.sv */
// checker on the address generator core ports
// assumes a bind onto adg_core; it tracks the instruction sampling phase itself
`timescale 1ns/100ps
`default_nettype none
module adg_core_props
    import adg_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // instruction and data port
    input wire adg_ins_t    ins_in,
    input wire logic [15:0] d_in,
    input wire logic [15:0] d_out,
    input wire logic        d_oe,
    // address port and flag
    input wire logic [15:0] y_out,
    input wire logic        y_oe,
    input wire logic        compare_zero_flag_pin,
    input wire logic        flag_oe,
    // register bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest
);
    // ------------------------------------------------------------
    // sampling phase helper
    // ------------------------------------------------------------
    logic    ph_q;
    logic    ph_d;
    logic    calm;
    adg_op_t op;
    adg_op_t op_q;
    adg_op_t op_d;
    assign op = ins_in.code.op;
    // a looping op may swap in the alternate word next slot, so such slots are skipped
    assign calm = !ph_q && !ins_in.alternate_exec_enable_pin && op_q != OP_ADD && op_q != OP_SUB;
    always_comb begin
        ph_d = ~ph_q;
        op_d = ph_q ? op_q : op;
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ph_q <= 1'b0;
            op_q <= OP_IDLE;
        end else begin
            ph_q <= ph_d;
            op_q <= op_d;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_pass; calm && op == OP_PASS |-> ##2 y_oe && y_out == $past(d_in, 2); endproperty
    a_pass: assert property (p_pass) else $error("address port lost the data value");
    property p_idle_off; calm && op == OP_IDLE |-> ##2 !y_oe && !d_oe && !flag_oe; endproperty
    a_idle_off: assert property (p_idle_off) else $error("pins driven after idle");
    property p_flag_hold;
        calm && (op == OP_IDLE || op == OP_BITREV) |->
            ##2 compare_zero_flag_pin == $past(compare_zero_flag_pin, 2);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag moved without a compare");
    property p_rtd; calm && op == OP_RTD |-> ##[1:2] d_oe; endproperty
    a_rtd: assert property (p_rtd) else $error("data drivers never enabled");
    property p_doe_one; d_oe |=> !d_oe; endproperty
    a_doe_one: assert property (p_doe_one) else $error("data drivers held past phase one");
    property p_rst;
        disable iff (1'b0) sys_rst |=> avs_waitrequest && !y_oe && !d_oe && !flag_oe && y_out == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("bus request not answered");
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_unmapped; avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_bitrev: cover property (calm && op == OP_BITREV);
    c_doe: cover property (d_oe);
    c_write: cover property (avs_write && !avs_waitrequest);
endmodule
`default_nettype wire

/* verif/adg_seq_model.sv */
// microcode sequencer and far side of the shared data bus
// assumes the core samples on every other edge from the first edge after reset
`timescale 1ns/100ps
`default_nettype none
module adg_seq_model
    import adg_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // toward the core
    output var adg_ins_t ins_out = '0,
    output logic [15:0]  d_out = 16'h0000,
    output int           sent = 0
);
    typedef struct packed {
        adg_ins_t    ins;
        logic [15:0] d;
    } adg_slot_t;
    adg_slot_t q[$];
    logic      ph_q = 1'b0;
    task automatic push(input adg_ins_t i, input logic [15:0] d);
        q.push_back({i, d});
    endtask
    always @(posedge clk) begin
        if (rst) begin
            ph_q <= 1'b0;
            ins_out <= '0;
            sent <= 0;
        end else begin
            ph_q <= ~ph_q;
            if (ph_q) begin
                // set up ahead of the sampling edge; idle when nothing is queued
                if (q.size() > 0) begin
                    {ins_out, d_out} <= q.pop_front();
                    sent <= sent + 1;
                end else begin
                    ins_out <= '0;
                    d_out <= ~d_out;
                end
            end else begin
                // scrambled during phase one on purpose, the core must not see it
                ins_out <= ~ins_out;
                d_out <= ~d_out;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/address_gen_misc_ops_timing_tb_top.sv */
// testbench for the address generator core
// assumes adg_seq_model as sequencer and adg_core_props bound below
`timescale 1ns/100ps
`default_nettype none
module address_gen_misc_ops_timing_tb_top
    import adg_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] rd;
    logic        avs_waitrequest, d_oe, y_oe, flag_oe, cmpf;
    logic [15:0] d_out, y_out, mdl_d, dbus, doe_val;
    adg_ins_t    ins;
    int          sent, error_cnt = 0, cmp_count = 0, cyc = 0, doe_n = 0;
    always #2.5 sys_clk = ~sys_clk;
    assign dbus = d_oe ? d_out : mdl_d;
    adg_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ins_in(ins), .d_in(dbus), .d_out(d_out),
        .d_oe(d_oe), .y_out(y_out), .y_oe(y_oe), .compare_zero_flag_pin(cmpf), .flag_oe(flag_oe),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    adg_seq_model seq (.clk(sys_clk), .rst(sys_rst), .ins_out(ins), .d_out(mdl_d), .sent(sent));
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // a hang stops here well beyond the under two hundred cycles the tests need
    always @(posedge sys_clk) begin
        cyc++;
        if (d_oe === 1'b1) begin
            doe_n++;
            doe_val = d_out;
        end
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // lat low samples just after the sampling edge, high one edge later
    task automatic run(input adg_op_t op, input logic [3:0] rs, input logic [1:0] ps, input logic ds,
                       input logic [15:0] d, input bit lat);
        int tgt;
        tgt = sent + 1;
        seq.push({op, rs, ps, ds, 1'b0}, d);
        do @(posedge sys_clk); while (sent != tgt);
        if (lat) @(posedge sys_clk);
        #1;
    endtask
    task automatic runy(input adg_op_t op, input logic [3:0] rs, input logic [1:0] ps, input logic ds,
                        input logic [15:0] d, input bit lat, input logic [15:0] ey);
        run(op, rs, ps, ds, d, lat);
        chk("y_out", {16'h0, y_out}, {16'h0, ey});
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        av(1'b0, ADG_OFS_CTRL, 32'h0);
        chk("ctrl", rd, {21'h0, ADG_CR_RESET});
        av(1'b0, 4'h2, 32'h0);
        chk("unmapped", rd, 32'h0);
        av(1'b1, ADG_OFS_ALT, 32'h089);
        av(1'b0, ADG_OFS_ALT, 32'h0);
        chk("alt", rd, 32'h089);
        $display("test registers done");
        runy(OP_PASS, 4'h0, 2'h0, 1'b0, 16'h1234, 1'b1, 16'h1234);
        chk("y_oe", {31'h0, y_oe}, 32'h1);
        run(OP_DTR, 4'h3, 2'h0, 1'b0, 16'h0001, 1'b1);
        run(OP_DTB, 4'h1, 2'h0, 1'b0, 16'h0003, 1'b1);
        runy(OP_BITREV, 4'h3, 2'h1, 1'b0, 16'h0000, 1'b1, 16'h8000);
        runy(OP_BITREV, 4'h3, 2'h1, 1'b0, 16'h0000, 1'b1, 16'h2000);
        run(OP_IDLE, 4'h3, 2'h1, 1'b0, 16'h0000, 1'b1);
        chk("idle_oe", {30'h0, y_oe, d_oe}, 32'h0);
        runy(OP_BITREV, 4'h3, 2'h1, 1'b0, 16'h0000, 1'b1, 16'he000);
        run(OP_RTD, 4'h3, 2'h0, 1'b0, 16'h0000, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("doe_cycles", doe_n, 32'h1);
        chk("d_out", {16'h0, doe_val}, 32'h000a);
        $display("test misc ops done");
        av(1'b1, ADG_OFS_CTRL, 32'h240);
        runy(OP_ADD, 4'h3, 2'h0, 1'b1, 16'h0100, 1'b0, 16'h010a);
        av(1'b1, ADG_OFS_CTRL, 32'h0);
        $display("test flow-through done");
        run(OP_DTC, 4'h0, 2'h0, 1'b0, 16'h0010, 1'b1);
        run(OP_DTR, 4'h2, 2'h0, 1'b0, 16'h000c, 1'b1);
        run(OP_DTB, 4'h0, 2'h0, 1'b0, 16'h0004, 1'b1);
        run(OP_DTI, 4'h0, 2'h0, 1'b0, 16'h0100, 1'b1);
        av(1'b1, ADG_OFS_CTRL, 32'h401);
        runy(OP_ADD, 4'h2, 2'h0, 1'b0, 16'h0000, 1'b1, 16'h000c);
        chk("flag", {31'h0, cmpf}, 32'h0);
        runy(OP_ADD, 4'h2, 2'h0, 1'b0, 16'h0000, 1'b1, 16'h0010);
        chk("flag", {31'h0, cmpf}, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("alt_y", {15'h0, y_oe, y_out}, 32'h12800);
        runy(OP_ADD, 4'h2, 2'h0, 1'b0, 16'h0000, 1'b1, 16'h0017);
        $display("test alternate done");
        run(OP_SETY, 4'h0, 2'h1, 1'b0, 16'h0000, 1'b1);
        run(OP_SETU, 4'h0, 2'h1, 1'b0, 16'h0000, 1'b1);
        av(1'b0, ADG_OFS_CTRL, 32'h0);
        chk("ctrl_modes", rd, 32'h641);
        run(OP_RST, 4'h0, 2'h0, 1'b0, 16'h0000, 1'b1);
        av(1'b0, ADG_OFS_CTRL, 32'h0);
        chk("ctrl_rst", rd, {21'h0, ADG_CR_RESET});
        $display("test mode ops done");
        give_verdict();
    end
endmodule
bind adg_core adg_core_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .ins_in(ins_in),
    .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .y_out(y_out), .y_oe(y_oe),
    .compare_zero_flag_pin(compare_zero_flag_pin), .flag_oe(flag_oe), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire
